/* File: epd_out_pkg.sv */
// Purpose: Shared constants for the display output pin and clock block.
// Assumes: 32-bit classic Wishbone register access, byte addressed.
// Notes: Offsets, field positions and most reset values live here; the segment registers reset to zero in the block.

package epd_out_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMING_CLK = 8'h04;
  localparam logic [7:0] REG_DOUBLER_CLK = 8'h08;
  localparam logic [7:0] REG_BOOSTER_CLK = 8'h0c;
  localparam logic [7:0] REG_POWER = 8'h10;
  localparam logic [7:0] REG_SEG_LOW = 8'h14;
  localparam logic [7:0] REG_SEG_HIGH = 8'h18;
  localparam logic [7:0] REG_WAVE_LEN = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_ARR_LSB = 0;
  localparam int CTRL_DRIVE_EN = 2;
  localparam int CTRL_START = 3;
  localparam int CTRL_IRQ_EN = 4;
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_DIV_LSB = 2;
  localparam int CLK_DEBUG_RUN = 5;
  localparam int PWR_VE_ON = 0;
  localparam int PWR_DOUBLER_ON = 1;
  localparam int PWR_BOOSTER_ON = 2;
  localparam int PWR_HVD_ON = 3;
  localparam int PWR_REF_SEL = 4;
  localparam int SEG_HIGH_BP = 10;
  localparam int SEG_HIGH_TP = 11;
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int NUM_SEG = 42;
  localparam int NUM_PINS = 44;
  localparam int SEG_LOW_W = 32;
  localparam int SEG_HIGH_W = 10;
  localparam int NUM_SRC = 4;
  localparam int DIV_CNT_W = 8;
  localparam logic [1:0] ARR_DIRECT = 2'h0;
  localparam logic [1:0] ARR_BP_FIRST = 2'h1;
  localparam logic [1:0] ARR_TP_FIRST = 2'h2;
  localparam logic [1:0] ARR_TP_BP_FIRST = 2'h3;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [5:0] CLK_CFG_RESET = 6'h00;
  localparam logic [4:0] PWR_RESET = 5'h00;
  localparam logic [7:0] WAVE_LEN_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    WAVE_IDLE = 2'b00,
    WAVE_TRIG = 2'b01,
    WAVE_RUN = 2'b10
  } wave_state_t;

endpackage

/* File: clk_tick_gen.sv */
// Purpose: Selects one synchronised clock source and divides it down.
// Assumes: src_lvl_i is already synchronised to clk_i.
// Notes: While halt_i is high the divider holds, so the clock freezes.

`timescale 1ns/1ps
`default_nettype none

module clk_tick_gen
  import epd_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NUM_SRC-1:0] src_lvl_i,
  input wire logic [1:0] source_sel_i,
  input wire logic [2:0] div_sel_i,
  input wire logic halt_i,
  output logic clk_o,
  output logic tick_o
);

  logic src_prev;
  logic [DIV_CNT_W-1:0] cnt;
  logic clk_prev;
  wire src_now = src_lvl_i[source_sel_i];
  wire src_rise = src_now & ~src_prev;
  wire div_lvl = cnt[div_sel_i];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev <= 1'b0;
      cnt <= '0;
      clk_prev <= 1'b0;
    end else begin
      src_prev <= src_now;
      if (src_rise && !halt_i) begin // RULE14 RULE15
        cnt <= cnt + 1'b1;
      end
      clk_prev <= div_lvl;
    end
  end

  assign clk_o = div_lvl;
  assign tick_o = div_lvl & ~clk_prev;

endmodule

`default_nettype wire

/* File: epd_output_pin_assign_clock_ctrl.sv */
// Purpose: Drive pin arrangement, external driver clock and trigger,
//          drive clock generation and supply path control.
// Assumes: Classic Wishbone slave, one aligned 32-bit word per register.
// Notes: Clock sources arrive from other domains and are synchronised.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE1: Forty-two segment pins plus back and top plane pins, each high or ground.
// RULE2: Arrangement 0: every logical output on its own physical pin.
// RULE3: Arrangement 1: back plane first, segments shift up one, seg41 on back pin.
// RULE4: Arrangement 2: top plane first, segments shift up, back plane on top pin.
// RULE5: Arrangement 3: top then back plane first, segments shift up two.
// RULE6: Drive, clock and trigger pins start undriven after reset.
// RULE7: A clock is driven out for an external panel driver.
// RULE8: A trigger pulse starts the external driver with our own sequence.
// RULE9: An interrupt is raised when waveform output has finished.
// RULE10: Software sets timing clock source and divider before use.
// RULE11: Software keeps the doubler clock between 8 and 32 kHz.
// RULE12: Software keeps the booster clock between 4 and 16 kHz.
// RULE13: Software clears oscillator sleep stop bits to run during sleep.
// RULE14: With debug run clear, each clock halts while the CPU debugs.
// RULE15: A halted clock resumes by itself when debug mode ends.
// RULE16: Register contents stay unchanged while clocks are halted.
// RULE17: With debug run set, the clock keeps running in debug mode.
// RULE18: Regulator, doubler, booster and high regulator switch on separately.
// RULE19: Reference select picks low level via doubler or doubled level direct.
// RULE20: Software clears the done flag by writing one before enabling it.
module epd_output_pin_assign_clock_ctrl
  import epd_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [NUM_SRC-1:0] src_clk_i,
  input wire logic debug_mode_i,
  output logic [NUM_SEG-1:0] phys_seg_pin_o,
  output logic [NUM_SEG-1:0] phys_seg_pin_oe_o,
  output logic phys_backplane_pin_o,
  output logic phys_backplane_pin_oe_o,
  output logic phys_topplane_pin_o,
  output logic phys_topplane_pin_oe_o,
  output logic ext_driver_clk_out_o,
  output logic ext_driver_clk_out_oe_o,
  output logic ext_driver_trig_out_o,
  output logic ext_driver_trig_out_oe_o,
  output logic display_timing_clk_o,
  output logic doubler_clk_o,
  output logic booster_clk_o,
  output logic ve_reg_on_o,
  output logic doubler_on_o,
  output logic booster_on_o,
  output logic hvd_reg_on_o,
  output logic boost_reference_sel_o,
  output logic update_irq_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Returns {top pin, back pin, segment pins}.
  function automatic logic [NUM_PINS-1:0] map_pins(input logic [1:0] arr,
                                     input logic [NUM_SEG-1:0] seg,
                                     input logic bp,
                                     input logic tp);
    logic [NUM_PINS-1:0] res;
    res = {tp, bp, seg};
    case (arr)
      ARR_DIRECT: res = {tp, bp, seg}; // RULE2
      ARR_BP_FIRST: res = {tp, seg[NUM_SEG-1], seg[NUM_SEG-2:0], bp}; // RULE3
      ARR_TP_FIRST: res = {bp, seg[NUM_SEG-1], seg[NUM_SEG-2:0], tp}; // RULE4
      ARR_TP_BP_FIRST: res = {seg[NUM_SEG-1], seg[NUM_SEG-2],
                              seg[NUM_SEG-3:0], bp, tp}; // RULE5
      default: res = {tp, bp, seg};
    endcase
    return res;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [4:0] ctrl;
  logic [5:0] timing_clk_cfg;
  logic [5:0] doubler_clk_cfg;
  logic [5:0] booster_clk_cfg;
  logic [4:0] power;
  logic [SEG_LOW_W-1:0] seg_low;
  logic [SEG_HIGH_W+1:0] seg_high;
  logic [7:0] wave_len;
  logic update_done_flag;
  wave_state_t state;
  wave_state_t next_state;
  logic [7:0] wave_cnt;
  logic [NUM_SRC-1:0] src_meta;
  logic [NUM_SRC-1:0] src_sync;
  logic [NUM_PINS-1:0] pin_level;
  logic trig_level;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire wr = bus_req & we_i;
  wire hit_ctrl = (adr_i == REG_CTRL);
  wire hit_tim = (adr_i == REG_TIMING_CLK);
  wire hit_dbl = (adr_i == REG_DOUBLER_CLK);
  wire hit_bst = (adr_i == REG_BOOSTER_CLK);
  wire hit_pwr = (adr_i == REG_POWER);
  wire hit_seg_low = (adr_i == REG_SEG_LOW);
  wire hit_seg_high = (adr_i == REG_SEG_HIGH);
  wire hit_wave = (adr_i == REG_WAVE_LEN);
  wire hit_stat = (adr_i == REG_STATUS);
  wire [31:0] wdata_ctrl = merge_bytes({27'h0, ctrl}, dat_i, sel_i);
  wire [31:0] wdata_tim = merge_bytes({26'h0, timing_clk_cfg}, dat_i, sel_i);
  wire [31:0] wdata_dbl = merge_bytes({26'h0, doubler_clk_cfg}, dat_i, sel_i);
  wire [31:0] wdata_bst = merge_bytes({26'h0, booster_clk_cfg}, dat_i, sel_i);
  wire [31:0] wdata_pwr = merge_bytes({27'h0, power}, dat_i, sel_i);
  wire [31:0] wdata_seg_low = merge_bytes(seg_low, dat_i, sel_i);
  wire [31:0] wdata_seg_high = merge_bytes({20'h0, seg_high}, dat_i, sel_i);
  wire [31:0] wdata_wave = merge_bytes({24'h0, wave_len}, dat_i, sel_i);
  wire start_req = wr & hit_ctrl & sel_i[0] & dat_i[CTRL_START];
  wire done_clear = wr & hit_stat & sel_i[0] & dat_i[STAT_DONE];
  wire busy = (state != WAVE_IDLE);

  logic [31:0] rdata;
  always_comb begin
    rdata = READ_ZERO;
    if (hit_ctrl) begin
      rdata = {27'h0, 1'b0 | ctrl[CTRL_IRQ_EN], 1'b0, ctrl[2:0]};
    end else if (hit_tim) begin
      rdata = {26'h0, timing_clk_cfg};
    end else if (hit_dbl) begin
      rdata = {26'h0, doubler_clk_cfg};
    end else if (hit_bst) begin
      rdata = {26'h0, booster_clk_cfg};
    end else if (hit_pwr) begin
      rdata = {27'h0, power};
    end else if (hit_seg_low) begin
      rdata = seg_low;
    end else if (hit_seg_high) begin
      rdata = {20'h0, seg_high};
    end else if (hit_wave) begin
      rdata = {24'h0, wave_len};
    end else if (hit_stat) begin
      rdata = {30'h0, busy, update_done_flag};
    end
  end

  // Unmapped addresses are acknowledged, read zero and ignore writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= READ_ZERO;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        dat_o <= rdata;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Nothing here depends on the drive clocks, so a debug halt of those
  // clocks leaves every stored value as it was.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET; // RULE6
      timing_clk_cfg <= CLK_CFG_RESET;
      doubler_clk_cfg <= CLK_CFG_RESET;
      booster_clk_cfg <= CLK_CFG_RESET;
      power <= PWR_RESET;
      seg_low <= '0;
      seg_high <= '0;
      wave_len <= WAVE_LEN_RESET;
    end else if (wr) begin // RULE16
      if (hit_ctrl) begin
        ctrl <= {wdata_ctrl[CTRL_IRQ_EN], 1'b0, wdata_ctrl[2:0]};
      end
      if (hit_tim) begin
        timing_clk_cfg <= wdata_tim[5:0];
      end
      if (hit_dbl) begin
        doubler_clk_cfg <= wdata_dbl[5:0];
      end
      if (hit_bst) begin
        booster_clk_cfg <= wdata_bst[5:0];
      end
      if (hit_pwr) begin
        power <= wdata_pwr[4:0]; // RULE18
      end
      if (hit_seg_low) begin
        seg_low <= wdata_seg_low;
      end
      if (hit_seg_high) begin
        seg_high <= wdata_seg_high[SEG_HIGH_W+1:0];
      end
      if (hit_wave) begin
        wave_len <= wdata_wave[7:0];
      end
    end
  end

  // ****************************************************************
  // Clock sources and dividers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_meta <= '0;
      src_sync <= '0;
    end else begin
      src_meta <= src_clk_i;
      src_sync <= src_meta;
    end
  end

  // Each clock halts in debug unless its own debug run bit is set.
  wire tim_halt = debug_mode_i & ~timing_clk_cfg[CLK_DEBUG_RUN]; // RULE17
  wire dbl_halt = debug_mode_i & ~doubler_clk_cfg[CLK_DEBUG_RUN]; // RULE17
  wire bst_halt = debug_mode_i & ~booster_clk_cfg[CLK_DEBUG_RUN]; // RULE17
  logic tim_clk;
  logic tim_tick;
  logic dbl_clk;
  logic bst_clk;

  clk_tick_gen timing_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_lvl_i(src_sync),
    .source_sel_i(timing_clk_cfg[CLK_SRC_LSB +: 2]),
    .div_sel_i(timing_clk_cfg[CLK_DIV_LSB +: 3]),
    .halt_i(tim_halt), // RULE14
    .clk_o(tim_clk),
    .tick_o(tim_tick)
  );

  clk_tick_gen doubler_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_lvl_i(src_sync),
    .source_sel_i(doubler_clk_cfg[CLK_SRC_LSB +: 2]),
    .div_sel_i(doubler_clk_cfg[CLK_DIV_LSB +: 3]),
    .halt_i(dbl_halt), // RULE14
    .clk_o(dbl_clk),
    .tick_o()
  );

  clk_tick_gen booster_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_lvl_i(src_sync),
    .source_sel_i(booster_clk_cfg[CLK_SRC_LSB +: 2]),
    .div_sel_i(booster_clk_cfg[CLK_DIV_LSB +: 3]),
    .halt_i(bst_halt), // RULE14
    .clk_o(bst_clk),
    .tick_o()
  );

  // ****************************************************************
  // Waveform sequencer
  // ****************************************************************
  // After the start request the sequence only advances on timing ticks,
  // so a debug halt pauses it and it carries on from the same point afterwards.
  always_comb begin
    next_state = state;
    case (state)
      WAVE_IDLE: begin
        if (start_req) begin
          next_state = WAVE_TRIG;
        end
      end
      WAVE_TRIG: begin
        if (tim_tick) begin
          next_state = WAVE_RUN;
        end
      end
      WAVE_RUN: begin
        if (tim_tick && wave_cnt == wave_len) begin
          next_state = WAVE_IDLE;
        end
      end
      default: next_state = WAVE_IDLE;
    endcase
  end

  wire wave_end = (state == WAVE_RUN) && (next_state == WAVE_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= WAVE_IDLE;
      wave_cnt <= '0;
      update_done_flag <= 1'b0;
    end else begin
      state <= next_state; // RULE15
      if (state != WAVE_RUN) begin
        wave_cnt <= '0;
      end else if (tim_tick) begin
        wave_cnt <= wave_cnt + 1'b1;
      end
      if (wave_end) begin
        update_done_flag <= 1'b1; // RULE9
      end else if (done_clear) begin
        update_done_flag <= 1'b0; // RULE20
      end
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  wire [NUM_SEG-1:0] logical_seg = {seg_high[SEG_HIGH_W-1:0], seg_low};
  wire [NUM_PINS-1:0] next_pin_level = map_pins(ctrl[CTRL_ARR_LSB +: 2],
      logical_seg, seg_high[SEG_HIGH_BP], seg_high[SEG_HIGH_TP]);
  wire drive_en = ctrl[CTRL_DRIVE_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_level <= '0;
      trig_level <= 1'b0;
    end else begin
      pin_level <= next_pin_level; // RULE1
      trig_level <= (next_state == WAVE_TRIG); // RULE8
    end
  end

  assign phys_seg_pin_o = pin_level[NUM_SEG-1:0];
  assign phys_backplane_pin_o = pin_level[NUM_SEG];
  assign phys_topplane_pin_o = pin_level[NUM_SEG+1];
  assign phys_seg_pin_oe_o = {NUM_SEG{drive_en}}; // RULE6
  assign phys_backplane_pin_oe_o = drive_en; // RULE6
  assign phys_topplane_pin_oe_o = drive_en; // RULE6
  assign ext_driver_clk_out_o = tim_clk & drive_en; // RULE7
  assign ext_driver_clk_out_oe_o = drive_en; // RULE6
  assign ext_driver_trig_out_o = trig_level; // RULE8
  assign ext_driver_trig_out_oe_o = drive_en; // RULE6
  assign display_timing_clk_o = tim_clk;
  assign doubler_clk_o = dbl_clk & power[PWR_DOUBLER_ON];
  assign booster_clk_o = bst_clk & power[PWR_BOOSTER_ON];
  assign ve_reg_on_o = power[PWR_VE_ON]; // RULE18
  assign doubler_on_o = power[PWR_DOUBLER_ON]; // RULE18
  assign booster_on_o = power[PWR_BOOSTER_ON]; // RULE18
  assign hvd_reg_on_o = power[PWR_HVD_ON]; // RULE18
  assign boost_reference_sel_o = power[PWR_REF_SEL]; // RULE19
  assign update_irq_o = update_done_flag & ctrl[CTRL_IRQ_EN]; // RULE9

endmodule

`default_nettype wire

/* File: epd_out_chk.sv */
// Purpose: Port-level checks for the display output block.
// Assumes: A write lands at the edge that takes the request.
// Notes: Only design outputs are judged.
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module epd_out_chk
  import epd_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic debug_mode_i,
  input wire logic [NUM_SEG-1:0] phys_seg_pin_o,
  input wire logic [NUM_SEG-1:0] phys_seg_pin_oe_o,
  input wire logic phys_backplane_pin_o,
  input wire logic phys_backplane_pin_oe_o,
  input wire logic phys_topplane_pin_o,
  input wire logic phys_topplane_pin_oe_o,
  input wire logic ext_driver_clk_out_o,
  input wire logic ext_driver_clk_out_oe_o,
  input wire logic ext_driver_trig_out_o,
  input wire logic ext_driver_trig_out_oe_o,
  input wire logic display_timing_clk_o,
  input wire logic ve_reg_on_o,
  input wire logic doubler_on_o,
  input wire logic booster_on_o,
  input wire logic hvd_reg_on_o,
  input wire logic boost_reference_sel_o
);
  logic tdbg;
  wire logic wr = cyc_i && stb_i && we_i;
  wire logic pwr_wr = wr && adr_i == REG_POWER;
  wire logic go = wr && adr_i == REG_CTRL && sel_i[0] && dat_i[CTRL_START];
  wire logic [4:0] pwr = {ve_reg_on_o, doubler_on_o, booster_on_o,
    hvd_reg_on_o, boost_reference_sel_o};
  wire logic [NUM_PINS-1:0] pins = {phys_topplane_pin_o,
    phys_backplane_pin_o, phys_seg_pin_o};
  wire logic [NUM_SEG+3:0] oe = {phys_seg_pin_oe_o, phys_backplane_pin_oe_o,
    phys_topplane_pin_oe_o, ext_driver_clk_out_oe_o, ext_driver_trig_out_oe_o};
  // The debug bit is mirrored here, since the checker cannot read it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdbg <= 1'b0;
    end else if (wr && !ack_o && adr_i == REG_TIMING_CLK && sel_i[0]) begin
      tdbg <= dat_i[CLK_DEBUG_RUN];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
  a_reset_hiz:
    assert property ($fell(rst_i) |-> oe == '0)
    else $error("pin driven after reset");
  a_oe_shared:
    assert property (oe == '0 || oe == '1)
    else $error("output enables disagree");
  a_clk_gated:
    assert property (ext_driver_clk_out_o ==
      (display_timing_clk_o && ext_driver_clk_out_oe_o))
    else $error("driver clock not the timing clock");
  a_trig_cause:
    assert property ($rose(ext_driver_trig_out_o) |->
      $past(go, 1) || $past(go, 2) || $past(go, 3))
    else $error("trigger without start");
  a_debug_hold:
    assert property (debug_mode_i && !tdbg |=> $stable(display_timing_clk_o))
    else $error("timing clock ran in debug");
  a_power_cause:
    assert property (!$stable(pwr) |-> $past(rst_i) || $past(pwr_wr, 1) ||
      $past(pwr_wr, 2))
    else $error("power bits changed unasked");
  a_pins_cause:
    assert property (!$stable(pins) |-> $past(rst_i) || $past(wr, 1) ||
      $past(wr, 2) || $past(wr, 3))
    else $error("pin level changed unasked");
endmodule
bind epd_output_pin_assign_clock_ctrl epd_out_chk epd_out_chk_inst (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .ack_o,
  .debug_mode_i, .phys_seg_pin_o, .phys_seg_pin_oe_o, .phys_backplane_pin_o,
  .phys_backplane_pin_oe_o, .phys_topplane_pin_o, .phys_topplane_pin_oe_o,
  .ext_driver_clk_out_o, .ext_driver_clk_out_oe_o, .ext_driver_trig_out_o,
  .ext_driver_trig_out_oe_o, .display_timing_clk_o, .ve_reg_on_o,
  .doubler_on_o, .booster_on_o, .hvd_reg_on_o, .boost_reference_sel_o);
`default_nettype wire

/* File: epd_panel_model.sv */
// Purpose: Panel side of the drive pins.
// Assumes: Pins have no pull resistors on the panel.
// Notes: An undriven pin flips every cycle, so stale levels never match.
`timescale 1ns/1ps
`default_nettype none
// ****
// Panel model
// ****
module epd_panel_model
  import epd_out_pkg::*;
(
  input wire logic clk_i,
  input wire logic [NUM_PINS-1:0] lvl_i,
  input wire logic [NUM_PINS-1:0] oe_i,
  output logic [NUM_PINS-1:0] seen_o
);
  logic [NUM_PINS-1:0] last = '0;
  assign seen_o = (lvl_i & oe_i) | (~last & ~oe_i);
  always @(posedge clk_i) begin
    last <= seen_o;
  end
endmodule
`default_nettype wire

/* File: epd_output_pin_assign_clock_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the display output block.
// Assumes: Clock sources are slow divisions of the bench clock.
// Notes: Expected values come from the model functions below.
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module epd_output_pin_assign_clock_ctrl_tb_top
  import epd_out_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, debug_mode_i = 1'b0, tprev = 1'b0, p;
  logic [7:0] adr_i = 8'h00, cnt = 8'h00;
  logic [3:0] sel_i = 4'h0, src_clk_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q, v;
  logic [NUM_SEG-1:0] seg, seg_oe;
  logic ack_o, bp, bp_oe, tp, tp_oe, eclk, eclk_oe, trig, trig_oe;
  logic tclk, dclk, bclk, ve, dbl, bst, hvd, rsel, irq;
  logic [NUM_PINS-1:0] seen;
  logic [63:0] s;
  int err_total = 0, cmp_count = 0, seed = 32'h2d65ea5a, trig_n = 0;
  int nt, nd, nb, len, n, r;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cnt <= cnt + 8'h01;
    src_clk_i <= cnt[5:2];
    tprev <= trig;
    if (trig === 1'b1 && tprev === 1'b0) trig_n++;
  end
  epd_output_pin_assign_clock_ctrl epd_output_pin_assign_clock_ctrl_inst (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .src_clk_i, .debug_mode_i, .phys_seg_pin_o(seg),
    .phys_seg_pin_oe_o(seg_oe), .phys_backplane_pin_o(bp),
    .phys_backplane_pin_oe_o(bp_oe), .phys_topplane_pin_o(tp),
    .phys_topplane_pin_oe_o(tp_oe), .ext_driver_clk_out_o(eclk),
    .ext_driver_clk_out_oe_o(eclk_oe), .ext_driver_trig_out_o(trig),
    .ext_driver_trig_out_oe_o(trig_oe), .display_timing_clk_o(tclk),
    .doubler_clk_o(dclk), .booster_clk_o(bclk), .ve_reg_on_o(ve),
    .doubler_on_o(dbl), .booster_on_o(bst), .hvd_reg_on_o(hvd),
    .boost_reference_sel_o(rsel), .update_irq_o(irq));
  epd_panel_model epd_panel_model_inst (.clk_i, .lvl_i({tp, bp, seg}),
    .oe_i({tp_oe, bp_oe, seg_oe}), .seen_o(seen));
  task automatic chk(input logic [63:0] sv, input logic [63:0] ev);
    cmp_count++;
    if (sv !== ev) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, sv, ev);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Holds the request until ack is sampled, so no wait length is assumed.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 40);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    chk(k < 40, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic toggles;
    logic pt, pd, pb;
    {nt, nd, nb} = '0;
    {pt, pd, pb} = {tclk, dclk, bclk};
    repeat (256) begin
      @(posedge clk_i);
      nt += int'(tclk !== pt);
      nd += int'(dclk !== pd);
      nb += int'(bclk !== pb);
      {pt, pd, pb} = {tclk, dclk, bclk};
    end
  endtask
  function automatic logic near(int c, int e);
    return c >= e - 1 && c <= e + 1;
  endfunction
  function automatic logic [43:0] pmap(int m, logic [63:0] x);
    logic [43:0] o;
    o = x[43:0];
    if (m == 1 || m == 2) o = {x[43], x[41:0], x[42]};
    if (m == 2) {o[43], o[0]} = {x[42], x[43]};
    if (m == 3) o = {x[41:0], x[42], x[43]};
    return o;
  endfunction
  initial begin
    #1000000;
    chk(1'b0, 1'b1);
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({seg_oe, bp_oe, tp_oe, eclk_oe, trig_oe, ve, dbl, irq}, 0);
    for (int a = 0; a <= 36; a += 4) rd(a[7:0], READ_ZERO);
    wb(1'b1, 8'h24, 32'hffffffff);
    rd(8'h24, READ_ZERO);
    repeat (2) begin
      s = {$random(seed), $random(seed)};
      wb(1'b1, REG_SEG_LOW, s[31:0]);
      wb(1'b1, REG_SEG_HIGH, {20'h0, s[43:32]});
      for (int m = 0; m < 4; m++) begin
        wb(1'b1, REG_CTRL, 32'h4 | m);
        repeat (2) @(posedge clk_i);
        chk({tp, bp, seg}, pmap(m, s));
        chk(seen, pmap(m, s));
        chk({tp_oe, bp_oe, seg_oe}, 44'hfffffffffff);
        rd(REG_CTRL, 32'h4 | m);
      end
    end
    repeat (4) begin
      v = $random(seed);
      wb(1'b1, REG_POWER, v);
      chk({rsel, hvd, bst, dbl, ve}, v[4:0]);
      rd(REG_POWER, {27'h0, v[4:0]});
    end
    wb(1'b1, REG_POWER, 32'h6);
    for (int d = 0; d < 3; d++) begin
      wb(1'b1, REG_TIMING_CLK, d << 2);
      wb(1'b1, REG_DOUBLER_CLK, 32'h1 | d << 2);
      wb(1'b1, REG_BOOSTER_CLK, 32'h2 | d << 2);
      toggles;
      chk(near(nt, 32 >> d) && near(nd, 16 >> d) && near(nb, 8 >> d), 1);
    end
    wb(1'b1, REG_POWER, 32'h0);
    toggles;
    chk(nd + nb, 0);
    wb(1'b1, REG_POWER, 32'h6);
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, REG_TIMING_CLK, m << 5);
      wb(1'b1, REG_DOUBLER_CLK, (1 - m) << 5 | 32'h1);
      wb(1'b1, REG_BOOSTER_CLK, m << 5 | 32'h2);
      debug_mode_i <= 1'b1;
      @(posedge clk_i);
      toggles;
      chk({nt > 0, nd > 0, nb > 0}, {m[0], !m[0], m[0]});
      debug_mode_i <= 1'b0;
      toggles;
      chk({nt > 0, nd > 0, nb > 0}, 3'b111);
      rd(REG_TIMING_CLK, m << 5);
    end
    wb(1'b1, REG_TIMING_CLK, 32'h0);
    len = $random(seed) & 7;
    wb(1'b1, REG_WAVE_LEN, len);
    wb(1'b1, REG_STATUS, 32'h1);
    trig_n = 0;
    wb(1'b1, REG_CTRL, 32'h1c);
    rd(REG_STATUS, 32'h2);
    wb(1'b1, REG_CTRL, 32'h1c);
    {n, r, p} = {32'd0, 32'd0, tclk};
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      chk(eclk, tclk);
      n++;
      if (trig === 1'b0 && tclk === 1'b1 && p === 1'b0) r++;
      p = tclk;
    end
    chk({near(r, len + 1), trig_n}, {1'b1, 32'd1});
    rd(REG_STATUS, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, k == 2 ? REG_STATUS : REG_CTRL, k == 2 ? 32'h1 : 32'h4 | k << 4);
      @(posedge clk_i);
      chk(irq, k == 1);
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({seg_oe, bp_oe, tp_oe, eclk_oe, trig_oe, irq}, 0);
    complete_run;
  end
endmodule
`default_nettype wire
